// ==== acf_aal1_former.sv ====
// acf_aal1_former: four-channel aal1 cell formation with a receive sequence check.
// assumes config inputs and the cell side run on ref_clk; line pins are asynchronous.
// Notes on behaviour
// - aal1 header octet leads every cell body, before payload.
// - unstructured cells carry 376 bits, 47 octets, after the header.
// - structured: seven cells of eight hold 47 octets, one holds 46 plus pointer.
// - unstructured: a full payload is sent at once with both headers.
// - sequence count rises modulo 8 in each new cell.
// - one csi bit beside the count, meaning set by service type.
// - three-bit crc covers the sequence number field.
// - parity bit covers csi, count and crc, seven bits.
// - time-stamp clocking puts four rts bits in odd cells' csi.
// - received counts are checked for order, loss and misinsertion.
// - pointer octet: offset in bits 6..0, even parity in bit 7.
// - pointer counts octets to next structure start; zero means first payload.
// - csi one in an even cell marks the second octet as pointer.
// - structured payload moves as whole aligned octets.
// - payload octets per cell are programmed per channel.
// - four channels run independently with own clocking and mapping.
// - cell port uses utopia cell-level flow control or synchronous fifo mode.
// - pointer goes in first even cell preceding a structure boundary.
// - no boundary in the cycle still gets a pointer of 127.
`timescale 1ns/100ps
`default_nettype none
module acf_aal1_former
  import acf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NUM_CH-1:0] line_clk,
  input wire logic [NUM_CH-1:0] line_dat,
  input wire logic [NUM_CH-1:0] line_sync,
  input wire logic [NUM_CH-1:0] chan_en,
  input wire logic [NUM_CH-1:0] struct_mode,
  input wire logic [NUM_CH-1:0] ts_mode,
  input wire logic [4*NUM_CH-1:0] rts_val,
  input wire logic [FILL_W*NUM_CH-1:0] fill_len,
  input wire logic [SIZE_W*NUM_CH-1:0] struct_size,
  input wire logic [32*NUM_CH-1:0] atm_hdr,
  input wire logic fifo_mode,
  input wire logic cell_ready,
  output logic [7:0] cell_data,
  output logic cell_soc,
  output logic cell_valid,
  output logic [1:0] cell_chan,
  output logic [NUM_CH-1:0] tx_ovf,
  input wire logic rx_valid,
  input wire logic rx_soc,
  input wire logic [7:0] rx_data,
  input wire logic [1:0] rx_chan,
  output logic [NUM_CH-1:0] rx_seq_err,
  output logic [NUM_CH-1:0] rx_hdr_err
);
  default clocking dcb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  typedef enum logic {ACF_IDLE, ACF_SEND} acf_tx_e;

  logic [7:0] ch_byte [NUM_CH];
  logic [2:0] ch_seq [NUM_CH];
  logic ch_csi [NUM_CH];
  logic ch_ptr [NUM_CH];
  logic [6:0] ch_pv [NUM_CH];
  logic [FILL_W-1:0] ch_cnt [NUM_CH];
  logic [1:0] ch_wr [NUM_CH];
  logic [1:0] rd_cnt_r [NUM_CH];
  logic [5:0] pay_idx;
  logic [NUM_CH-1:0] ovf_r;

  // ==========================================================
  // per-channel collectors, two cell banks each
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    logic [2:0] s1_r, s2_r;
    logic clk_d_r, bsync_r, synced_r, pdone_r, cptr_r;
    logic [2:0] bit_cnt_r, cseq_r;
    logic [6:0] shift_r, cpv_r;
    logic [5:0] idx_r;
    logic [SIZE_W-1:0] rem_r;
    logic [1:0] wr_cnt_r;
    logic [7:0] mem [2][PAY_FULL];
    logic [2:0] mseq_r [2];
    logic mcsi_r [2];
    logic mptr_r [2];
    logic [6:0] mpv_r [2];
    logic [FILL_W-1:0] mcnt_r [2];
    wire en = chan_en[c];
    wire st = struct_mode[c];
    wire [FILL_W-1:0] fl_raw = fill_len[FILL_W*c +: FILL_W];
    wire [FILL_W-1:0] fill = (fl_raw < FILL_W'(PAY_MIN)) ? FILL_W'(PAY_MIN) :
                             (fl_raw > FILL_W'(PAY_FULL)) ? FILL_W'(PAY_FULL) : fl_raw;
    wire [SIZE_W-1:0] ssz = struct_size[SIZE_W*c +: SIZE_W];
    wire rise = s2_r[2] & ~clk_d_r;
    wire sync_now = st & s2_r[0];
    wire [2:0] eff_cnt = sync_now ? 3'h0 : bit_cnt_r;
    wire byte_done = en & rise & (eff_cnt == 3'h7);
    wire byte_sync = bsync_r;
    wire [7:0] new_byte = {shift_r, s2_r[1]};
    wire [SIZE_W-1:0] offv = byte_sync ? '0 : rem_r;
    wire [SIZE_W-1:0] win = SIZE_W'({fill, 1'b0}) - SIZE_W'(2);
    wire in_reach = (synced_r | byte_sync) & (offv <= win);
    wire ptr_take = st & ~cseq_r[0] & ~pdone_r &
                    (in_reach | (cseq_r == 3'(PTR_SEQ_LAST)));
    wire [6:0] ptr_v = in_reach ? offv[6:0] : PTR_NONE;
    wire cur_ptr = (idx_r == '0) ? ptr_take : cptr_r;
    wire [6:0] cur_pv = (idx_r == '0) ? ptr_v : cpv_r;
    wire [5:0] limit = cur_ptr ? 6'(fill - FILL_W'(1)) : 6'(fill);
    wire full = (wr_cnt_r - rd_cnt_r[c]) == 2'h2;
    wire wr_ok = byte_done & ~full;
    wire close = wr_ok & (idx_r == limit - 6'h1);
    wire rts_bit = rts_val[4*c + 3 - 32'(cseq_r[2:1])];
    wire csi = cseq_r[0] ? (ts_mode[c] & rts_bit) : (st & cur_ptr);
    wire rb = rd_cnt_r[c][0];

    assign ch_byte[c] = mem[rb][pay_idx];
    assign ch_seq[c] = mseq_r[rb];
    assign ch_csi[c] = mcsi_r[rb];
    assign ch_ptr[c] = mptr_r[rb];
    assign ch_pv[c] = mpv_r[rb];
    assign ch_cnt[c] = mcnt_r[rb];
    assign ch_wr[c] = wr_cnt_r;

    // line pins pass two flops before any use
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        s1_r <= '0;
        s2_r <= '0;
        clk_d_r <= 1'b0;
      end
      else
      begin
        s1_r <= {line_clk[c], line_dat[c], line_sync[c]};
        s2_r <= s1_r;
        clk_d_r <= s2_r[2];
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        bit_cnt_r <= '0;
        shift_r <= '0;
        bsync_r <= 1'b0;
        synced_r <= 1'b0;
        rem_r <= '0;
      end
      else if (!en)
      begin
        bit_cnt_r <= '0;
        bsync_r <= 1'b0;
        synced_r <= 1'b0;
      end
      else if (rise)
      begin
        bit_cnt_r <= eff_cnt + 3'h1;
        shift_r <= {shift_r[5:0], s2_r[1]};
        if (eff_cnt == 3'h0)
          bsync_r <= sync_now;
        if (byte_done)
        begin
          synced_r <= synced_r | byte_sync;
          rem_r <= (byte_sync || rem_r == '0) ? ssz - SIZE_W'(1) : rem_r - SIZE_W'(1);
        end
      end
    end

    // cell assembly; disabled channel restarts its count and cycle
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        idx_r <= '0;
        cseq_r <= '0;
        pdone_r <= 1'b0;
        cptr_r <= 1'b0;
        cpv_r <= '0;
        wr_cnt_r <= '0;
        ovf_r[c] <= 1'b0;
      end
      else if (!en)
      begin
        idx_r <= '0;
        cseq_r <= '0;
        pdone_r <= 1'b0;
        ovf_r[c] <= 1'b0;
      end
      else
      begin
        ovf_r[c] <= byte_done & full;
        if (wr_ok)
        begin
          cptr_r <= cur_ptr;
          cpv_r <= cur_pv;
          idx_r <= close ? '0 : idx_r + 6'h1;
        end
        if (close)
        begin
          wr_cnt_r <= wr_cnt_r + 2'h1;
          cseq_r <= cseq_r + 3'h1;
          pdone_r <= (cseq_r == 3'(LAST_SEQ)) ? 1'b0 : (pdone_r | cur_ptr);
        end
      end
    end

    // storage has no reset; a bank is read only after its close
    always_ff @(posedge ref_clk)
    begin
      if (wr_ok)
        mem[wr_cnt_r[0]][idx_r] <= new_byte;
      if (close)
      begin
        mseq_r[wr_cnt_r[0]] <= cseq_r;
        mcsi_r[wr_cnt_r[0]] <= csi;
        mptr_r[wr_cnt_r[0]] <= cur_ptr;
        mpv_r[wr_cnt_r[0]] <= cur_pv;
        mcnt_r[wr_cnt_r[0]] <= FILL_W'(limit);
      end
    end

    a_ptr_payload: assert property (close && st |->
      idx_r + 6'(cur_ptr) == 6'(fill - FILL_W'(1))) else $error("structured payload size wrong");
    a_ptr_last_even: assert property (close && st && cseq_r == 3'h6 |->
      cur_ptr || pdone_r) else $error("cycle ended without pointer");
    a_even_csi_zero: assert property (close && st && !cseq_r[0] && !cur_ptr |->
      !csi) else $error("even cell csi set without pointer");
    a_enable_restart: assert property (!en |=> cseq_r == 3'h0 && idx_r == '0)
      else $error("disabled channel did not restart");
    a_seq_wrap: assert property (close && cseq_r == 3'h7 |=> cseq_r == 3'h0)
      else $error("sequence count not modulo 8");
  end

  // ==========================================================
  // cell transmitter, round robin over ready channels
  acf_tx_e state_r;
  logic [1:0] sel_r, pick;
  logic [5:0] pos_r;
  logic [7:0] data_r;
  logic soc_r, valid_r, any_avail;
  logic [NUM_CH-1:0] avail;
  acf_hdr_if tx_h ();
  acf_hdr_gen u_tx_hdr (.h(tx_h));

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_av
    assign avail[c] = chan_en[c] & (ch_wr[c] != rd_cnt_r[c]);
  end

  always_comb
  begin
    pick = sel_r;
    any_avail = 1'b0;
    for (int k = NUM_CH; k >= 1; k--)
    begin
      if (avail[2'(sel_r + 2'(k))])
      begin
        pick = 2'(sel_r + 2'(k));
        any_avail = 1'b1;
      end
    end
  end

  wire has_ptr = ch_ptr[sel_r];
  assign pay_idx = pos_r - 6'(PTR_POS) - {5'h0, has_ptr};
  assign tx_h.seq = ch_seq[sel_r];
  assign tx_h.csi = ch_csi[sel_r];
  assign tx_h.ptr_val = ch_pv[sel_r];
  wire [31:0] hdr_word = atm_hdr[{sel_r, 5'h00} +: 32];
  wire [7:0] atm_byte = hdr_word[8*(3 - 32'(pos_r[1:0])) +: 8];
  wire is_pay = pos_r > 6'(AAL_HDR_POS) + {5'h0, has_ptr};
  wire [7:0] pay_byte = (pay_idx < 6'(ch_cnt[sel_r])) ? ch_byte[sel_r] : PAD_BYTE;
  wire [7:0] tx_byte = (pos_r < 6'(ATM_HDR_LEN)) ? atm_byte :
                       (pos_r == 6'(HEC_POS)) ? HEC_SLOT :
                       (pos_r == 6'(AAL_HDR_POS)) ? tx_h.hdr_byte :
                       !is_pay ? tx_h.ptr_byte : pay_byte;
  wire advance = fifo_mode ? (~valid_r | cell_ready) : 1'b1;
  wire start = (state_r == ACF_IDLE) & any_avail & (fifo_mode | cell_ready);
  wire load = (state_r == ACF_SEND) & advance;
  wire last = load & (pos_r == 6'(CELL_LEN - 1));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ACF_IDLE;
      sel_r <= '0;
      pos_r <= '0;
    end
    else
    begin
      case (state_r)
        ACF_IDLE:
          if (start)
          begin
            state_r <= ACF_SEND;
            sel_r <= pick;
            pos_r <= '0;
          end
        ACF_SEND:
          if (last)
            state_r <= ACF_IDLE;
          else if (load)
            pos_r <= pos_r + 6'h1;
        default:
          state_r <= ACF_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_r <= '0;
      soc_r <= 1'b0;
      valid_r <= 1'b0;
    end
    else if (load)
    begin
      data_r <= tx_byte;
      soc_r <= pos_r == '0;
      valid_r <= 1'b1;
    end
    else if (advance)
    begin
      soc_r <= 1'b0;
      valid_r <= 1'b0;
    end
  end

  // disabled channels drop queued cells so a re-enable starts clean
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_rd
    wire busy = (state_r == ACF_SEND) & (sel_r == 2'(c));
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        rd_cnt_r[c] <= '0;
      else if (last && sel_r == 2'(c))
        rd_cnt_r[c] <= rd_cnt_r[c] + 2'h1;
      else if (!chan_en[c] && !busy)
        rd_cnt_r[c] <= ch_wr[c];
    end
  end

  // ==========================================================
  // receive header check
  logic [5:0] rx_pos_r;
  logic [2:0] exp_r [NUM_CH];
  logic [NUM_CH-1:0] seen_r, seq_err_r, hdr_err_r;
  acf_hdr_if rx_h ();
  acf_hdr_gen u_rx_hdr (.h(rx_h));
  assign rx_h.seq = rx_data[6:4];
  assign rx_h.csi = rx_data[7];
  assign rx_h.ptr_val = '0;
  wire [5:0] rx_cur = rx_soc ? 6'h0 : rx_pos_r;
  wire rx_chk = rx_valid & (rx_cur == 6'(AAL_HDR_POS));
  wire rx_bad = rx_h.hdr_byte != rx_data;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_pos_r <= '0;
    else if (rx_valid && rx_cur != 6'h3F)
      rx_pos_r <= rx_cur + 6'h1;
  end

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_rx
    wire hit = rx_chk & (rx_chan == 2'(c));
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        exp_r[c] <= '0;
        seen_r[c] <= 1'b0;
        seq_err_r[c] <= 1'b0;
        hdr_err_r[c] <= 1'b0;
      end
      else
      begin
        seq_err_r[c] <= hit & ~rx_bad & seen_r[c] & (rx_data[6:4] != exp_r[c]);
        hdr_err_r[c] <= hit & rx_bad;
        if (!chan_en[c])
          seen_r[c] <= 1'b0;
        else if (hit && !rx_bad)
        begin
          exp_r[c] <= rx_data[6:4] + 3'h1;
          seen_r[c] <= 1'b1;
        end
      end
    end
  end

  assign cell_data = data_r;
  assign cell_soc = soc_r;
  assign cell_valid = valid_r;
  assign cell_chan = sel_r;
  assign tx_ovf = ovf_r;
  assign rx_seq_err = seq_err_r;
  assign rx_hdr_err = hdr_err_r;

  // ==========================================================
  // checks
  a_aal_hdr_slot: assert property (load && pos_r == 6'(AAL_HDR_POS) |=>
    cell_data == $past(tx_h.hdr_byte) && !cell_soc) else $error("aal1 header misplaced");
  a_hdr_parity: assert property (load && pos_r == 6'(AAL_HDR_POS) |=> !(^cell_data))
    else $error("header parity odd");
  a_ptr_parity: assert property (load && pos_r == 6'(PTR_POS) && has_ptr |=>
    !(^cell_data)) else $error("pointer parity odd");
  a_utopia_burst: assert property (!fifo_mode && start ##1 !fifo_mode |=>
    cell_valid && cell_soc ##1 cell_valid [*8]) else $error("utopia cell broke up");
  a_fifo_hold: assert property (fifo_mode && cell_valid && !cell_ready |=>
    cell_valid && $stable(cell_data)) else $error("fifo byte not held");
  a_rx_seq_flag: assert property (rx_chk && !rx_bad && seen_r[rx_chan] &&
    rx_data[6:4] != exp_r[rx_chan] |=> rx_seq_err[$past(rx_chan)])
    else $error("sequence gap not flagged");
  a_cell_ends: assert property (start |-> ##[53:300] state_r == ACF_IDLE)
    else $error("cell never finished");
  c_utopia_cell: cover property (!fifo_mode && last);
  c_fifo_stall: cover property (fifo_mode && cell_valid && !cell_ready);
  c_rx_seq_err: cover property (|rx_seq_err);
endmodule
`default_nettype wire

// ==== acf_cell_sink.sv ====
// acf_cell_sink: atm-layer model that takes cells from the former.
// assumes the cell port runs on ref_clk; stall makes it answer slowly.
`timescale 1ns/100ps
`default_nettype none
module acf_cell_sink
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fifo_mode,
  input wire logic stall,
  input wire logic [7:0] cell_data,
  input wire logic cell_soc,
  input wire logic cell_valid,
  output logic cell_ready,
  output logic [7:0] cell_buf_r [0:52],
  output int cell_cnt_r
);
  logic [2:0] pace_r;
  int idx_r;
  // utopia ignores ready mid cell, fifo needs it on every byte
  wire take = cell_valid && (cell_ready || !fifo_mode);
  // slow answer: ready low five cycles of eight
  assign cell_ready = !stall || (pace_r > 3'h4);
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      pace_r <= 3'h0;
      idx_r <= 0;
      cell_cnt_r <= 0;
    end
    else
    begin
      pace_r <= pace_r + 3'h1;
      if (take)
      begin
        cell_buf_r[cell_soc ? 0 : idx_r] <= cell_data;
        idx_r <= cell_soc ? 1 : idx_r + 1;
        if (!cell_soc && idx_r == 52)
          cell_cnt_r <= cell_cnt_r + 1;
      end
    end
endmodule
`default_nettype wire

// ==== acf_hdr_gen.sv ====
// acf_hdr_gen: builds the aal1 header octet and the structure pointer octet.
// assumes inputs are stable within the cycle; no state is kept here.
`timescale 1ns/100ps
`default_nettype none
module acf_hdr_gen
  import acf_pkg::*;
(
  acf_hdr_if.gen h
);
  // ==========================================================
  // crc-3 over csi and sequence count, then even parity
  logic [6:0] sn_prot;
  always_comb
  begin
    logic [2:0] rem;
    logic [3:0] sn;
    logic fb;
    rem = 3'h0;
    sn = {h.csi, h.seq};
    fb = 1'b0;
    for (int i = 3; i >= 0; i--)
    begin
      fb = rem[2] ^ sn[i];
      rem = {rem[1:0], 1'b0} ^ (fb ? CRC_POLY : 3'h0);
    end
    sn_prot = {sn, rem};
  end
  assign h.hdr_byte = {sn_prot, ^sn_prot};
  assign h.ptr_byte = {^h.ptr_val, h.ptr_val};
endmodule
`default_nettype wire

// ==== acf_hdr_if.sv ====
// acf_hdr_if: carries header fields to the header encoder and the coded bytes back.
// assumes both ends sit on the same clock; the path is purely combinational.
`timescale 1ns/100ps
`default_nettype none
interface acf_hdr_if;
  logic [2:0] seq;
  logic csi;
  logic [6:0] ptr_val;
  logic [7:0] hdr_byte;
  logic [7:0] ptr_byte;
  modport gen (input seq, input csi, input ptr_val, output hdr_byte, output ptr_byte);
  modport user (output seq, output csi, output ptr_val, input hdr_byte, input ptr_byte);
endinterface
`default_nettype wire

// ==== acf_pkg.sv ====
// acf_pkg: shared constants of the four-channel aal1 cell former.
// assumes a single 20 MHz reference clock drives all users.
package acf_pkg;
  // ==========================================================
  // cell geometry
  localparam int NUM_CH = 4;
  localparam int CELL_LEN = 53;
  localparam int ATM_HDR_LEN = 4;
  localparam int HEC_POS = 4;
  localparam int AAL_HDR_POS = 5;
  localparam int PTR_POS = 6;
  localparam int PAY_FULL = 47;
  localparam int PAY_MIN = 2;
  localparam int LAST_SEQ = 7;
  localparam int PTR_SEQ_LAST = 6;
  localparam int SIZE_W = 10;
  localparam int FILL_W = 6;
  // ==========================================================
  // byte values
  localparam logic [6:0] PTR_NONE = 7'h7F;
  localparam logic [7:0] HEC_SLOT = 8'h00;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic [2:0] CRC_POLY = 3'h3;
endpackage

// ==== test_acf_aal1_former.sv ====
// test_acf_aal1_former: self-checking bench for the aal1 cell former.
// assumes acf_pkg and the sink model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_acf_aal1_former;
  import acf_pkg::*;
  typedef struct {int fill; logic [2:0] seq; logic csi;} acf_row_s;
  logic ref_clk, rst_n, fifo_mode, cell_ready, cell_soc, cell_valid, stall;
  logic rx_valid, rx_soc;
  logic [3:0] line_clk, line_dat, line_sync, chan_en, struct_mode, ts_mode;
  logic [3:0] tx_ovf, rx_seq_err, rx_hdr_err;
  logic [15:0] rts_val;
  logic [23:0] fill_len;
  logic [39:0] struct_size;
  logic [127:0] atm_hdr;
  logic [7:0] cell_data, rx_data;
  logic [1:0] cell_chan, rx_chan;
  logic [7:0] sink_buf [0:52];
  logic [7:0] base;
  int sink_cnt, bad_count, checks;
  logic ovf_seen;
  acf_row_s rows [9] = '{'{2, 1, 1}, '{5, 2, 0}, '{3, 3, 0}, '{4, 4, 0}, '{2, 5, 1},
    '{6, 6, 0}, '{3, 7, 0}, '{2, 0, 0}, '{2, 1, 1}};

  acf_aal1_former DUT (.ref_clk(ref_clk), .rst_n(rst_n), .line_clk(line_clk),
    .line_dat(line_dat), .line_sync(line_sync), .chan_en(chan_en),
    .struct_mode(struct_mode), .ts_mode(ts_mode), .rts_val(rts_val),
    .fill_len(fill_len), .struct_size(struct_size), .atm_hdr(atm_hdr),
    .fifo_mode(fifo_mode), .cell_ready(cell_ready), .cell_data(cell_data),
    .cell_soc(cell_soc), .cell_valid(cell_valid), .cell_chan(cell_chan),
    .tx_ovf(tx_ovf), .rx_valid(rx_valid), .rx_soc(rx_soc), .rx_data(rx_data),
    .rx_chan(rx_chan), .rx_seq_err(rx_seq_err), .rx_hdr_err(rx_hdr_err));
  acf_cell_sink sink (.ref_clk(ref_clk), .rst_n(rst_n), .fifo_mode(fifo_mode),
    .stall(stall), .cell_data(cell_data), .cell_soc(cell_soc),
    .cell_valid(cell_valid), .cell_ready(cell_ready), .cell_buf_r(sink_buf),
    .cell_cnt_r(sink_cnt));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // sticky: the overflow pulse lasts one cycle only
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n) ovf_seen <= 1'b0;
    else if (tx_ovf !== 4'h0) ovf_seen <= 1'b1;
  // ==========================================================
  // helpers
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic close_out();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  // crc x^3+x+1 over csi and count, then even parity over the octet
  function automatic logic [7:0] hdr(input logic csi, input logic [2:0] seq);
    logic [3:0] sn;
    logic [2:0] r;
    sn = {csi, seq};
    r = 3'h0;
    for (int i = 3; i >= 0; i--)
      r = {r[1:0], 1'b0} ^ ((sn[i] ^ r[2]) ? CRC_POLY : 3'h0);
    return {sn, r, ^{sn, r}};
  endfunction
  // msb first; each line clock phase lasts three reference cycles
  task automatic send_oct(input int ch, input int n, input logic [7:0] b0, input logic sy);
    logic [7:0] v;
    for (int o = 0; o < n; o++)
    begin
      v = b0 + o[7:0];
      for (int b = 7; b >= 0; b--)
      begin
        line_dat[ch] = v[b];
        line_sync[ch] = sy && o == 0 && b == 7;
        repeat (3) step();
        line_clk[ch] = 1'b1;
        repeat (3) step();
        line_clk[ch] = 1'b0;
      end
    end
    line_sync[ch] = 1'b0;
  endtask
  task automatic get_cell(input int lim);
    int n0;
    n0 = sink_cnt;
    for (int n = 0; n < lim && sink_cnt == n0; n++)
      step();
    if (sink_cnt == n0)
    begin
      $display("MISMATCH cell arrival expected 1 seen 0");
      bad_count++;
      close_out();
    end
  endtask
  // off below zero: no pointer octet expected in this cell
  task automatic check_cell(input int ch, input logic [2:0] seq, input logic csi,
    input int fill, input logic [7:0] b0, input int off);
    int hp;
    int pos;
    logic [7:0] e;
    hp = (off >= 0) ? 1 : 0;
    for (int i = 0; i < 53; i++)
    begin
      pos = i - 6 - hp;
      if (i < 4) e = atm_hdr[32 * ch + 31 - 8 * i -: 8];
      else if (i == 4) e = HEC_SLOT;
      else if (i == 5) e = hdr(csi, seq);
      else if (hp == 1 && i == 6) e = {^off[6:0], off[6:0]};
      else if (pos < fill - hp) e = b0 + pos[7:0];
      else e = PAD_BYTE;
      chk($sformatf("cell byte %0d", i), e, sink_buf[i]);
    end
    chk("cell chan", {6'h00, ch[1:0]}, {6'h00, cell_chan});
  endtask
  task automatic rx_cell(input logic [7:0] h, input logic [3:0] es, input logic [3:0] eh);
    for (int i = 0; i < 53; i++)
    begin
      step();
      rx_valid = 1'b1;
      rx_soc = (i == 0);
      rx_data = (i == 5) ? h : 8'h00;
      if (i == 6) chk("rx seq err", {4'h0, es}, {4'h0, rx_seq_err});
      if (i == 6) chk("rx hdr err", {4'h0, eh}, {4'h0, rx_hdr_err});
    end
    step();
    rx_valid = 1'b0;
    rx_soc = 1'b0;
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    bad_count = 0;
    checks = 0;
    {rst_n, fifo_mode, stall, rx_valid, rx_soc} = 5'h00;
    {line_clk, line_dat, line_sync, chan_en} = 16'h0000;
    struct_mode = 4'h6;
    ts_mode = 4'h1;
    rts_val = 16'h000A;
    fill_len = {6'h02, 6'h02, 6'h04, 6'h2F};
    struct_size = {10'h001, 10'h001, 10'h006, 10'h001};
    atm_hdr = 128'h3131_3232_2121_2222_1111_1212_0A0B_0C0D;
    rx_data = 8'h00;
    rx_chan = 2'h3;
    repeat (10) step();
    rst_n = 1'b1;
    repeat (2) step();
    chan_en = 4'h9;
    step();
    send_oct(0, 47, 8'h40, 1'b0);
    get_cell(120);
    check_cell(0, 3'h0, 1'b0, 47, 8'h40, -1);
    for (int k = 0; k < 9; k++)
    begin
      base = {k[3:0], 4'h0};
      fill_len[5:0] = rows[k].fill[5:0];
      send_oct(0, rows[k].fill, base, 1'b0);
      get_cell(120);
      check_cell(0, rows[k].seq, rows[k].csi, rows[k].fill, base, -1);
    end
    chan_en[0] = 1'b0;
    repeat (2) step();
    chan_en[0] = 1'b1;
    step();
    send_oct(0, 2, 8'hA0, 1'b0);
    get_cell(120);
    check_cell(0, 3'h0, 1'b0, 2, 8'hA0, -1);
    // slow sink in both cell port schemes
    fifo_mode = 1'b1;
    stall = 1'b1;
    send_oct(0, 2, 8'hB0, 1'b0);
    get_cell(600);
    check_cell(0, 3'h1, 1'b1, 2, 8'hB0, -1);
    fifo_mode = 1'b0;
    send_oct(0, 2, 8'hC0, 1'b0);
    get_cell(600);
    check_cell(0, 3'h2, 1'b0, 2, 8'hC0, -1);
    stall = 1'b0;
    chan_en[1] = 1'b1;
    step();
    send_oct(1, 3, 8'h70, 1'b1);
    get_cell(120);
    check_cell(1, 3'h0, 1'b1, 4, 8'h70, 0);
    chan_en[2] = 1'b1;
    step();
    for (int k = 0; k < 7; k++)
    begin
      base = {4'h8, k[3:0]};
      send_oct(2, (k == 6) ? 1 : 2, base, 1'b0);
      get_cell(120);
      check_cell(2, k[2:0], k == 6, 2, base, (k == 6) ? 127 : -1);
    end
    rx_cell(hdr(1'b0, 3'h0), 4'h0, 4'h0);
    rx_cell(hdr(1'b0, 3'h1), 4'h0, 4'h0);
    rx_cell(hdr(1'b0, 3'h3), 4'h8, 4'h0);
    rx_cell(hdr(1'b0, 3'h4) ^ 8'h01, 4'h0, 4'h8);
    chk("tx ovf seen", 8'h00, {7'h00, ovf_seen});
    // slow fifo sink while cells pile up: both banks fill and an octet is dropped
    fifo_mode = 1'b1;
    stall = 1'b1;
    send_oct(0, 8, 8'hD0, 1'b0);
    chk("tx ovf seen", 8'h01, {7'h00, ovf_seen});
    close_out();
  end
endmodule
`default_nettype wire
